// >>> capture_timer_mode_control_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module capture_timer_mode_control_test;
	import ctmc_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [1:0]  cap_in = 2'h0;
	logic        ext_clk = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs, cap_ev;
	logic [31:0] rdata, rd;
	logic [7:0]  t1, t2, mode;
	logic [15:0] snap;
	int          fail_count = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          ev_cnt [2] = '{0, 0};
	ctmc_capture_timer_mode_control dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_timer_clk(ext_clk), .capture_in(cap_in),
		.capture_event(cap_ev), .timer1_count(t1), .timer2_count(t2), .mode_ctrl(mode));
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		ev_cnt[0] <= ev_cnt[0] + int'(cap_ev[0] === 1'b1);
		ev_cnt[1] <= ev_cnt[1] + int'(cap_ev[1] === 1'b1);
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_read
	// Both capture inputs get the same pulses; each field is set to the same mode
	task automatic capture_run(input logic [1:0] m, input int n, input int e);
		int b0;
		int b1;
		axi_write(CTMC_ADDR_MODE_CTRL, {m, m, 4'h0});
		b0 = ev_cnt[0];
		b1 = ev_cnt[1];
		repeat (n) begin
			@(posedge aclk);
			cap_in <= 2'h3;
			repeat (3) @(posedge aclk);
			cap_in <= 2'h0;
			repeat (3) @(posedge aclk);
		end
		repeat (3) @(posedge aclk);
		`CHK(ev_cnt[0] - b0, e)
		`CHK(ev_cnt[1] - b1, e)
	endtask : capture_run
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(CTMC_ADDR_MODE_CTRL, rd, rs);
		`CHK(rd, 32'h00000000)
		for (int i = 0; i < 8; i++) begin
			axi_write(CTMC_ADDR_MODE_CTRL, 8'h01 << i);
			axi_read(CTMC_ADDR_MODE_CTRL, rd, rs);
			`CHK(rd, {24'h000000, 8'h01 << i})
		end
		axi_read(12'h004, rd, rs);
		`CHK(rs, CTMC_RESP_SLVERR)
		`CHK(rd, 32'h00000000)
		// 1024 cycles are 256 ticks: only a cascaded pair moves the high byte
		for (int c = 0; c < 2; c++) begin
			axi_write(CTMC_ADDR_MODE_CTRL, 8'(c * 8));
			@(posedge aclk);
			snap = {t2, t1};
			repeat (1024) @(posedge aclk);
			`CHK({t2, t1}, {snap[15:8] + 8'(c), snap[7:0]})
		end
		// Both timers on the external pin: five falling edges, no internal ticks
		axi_write(CTMC_ADDR_MODE_CTRL, 8'h03);
		@(posedge aclk);
		snap = {t2, t1};
		repeat (5) begin
			@(posedge aclk);
			ext_clk <= 1'b1;
			repeat (2) @(posedge aclk);
			ext_clk <= 1'b0;
			repeat (2) @(posedge aclk);
		end
		`CHK({t2, t1}, {snap[15:8] + 8'h05, snap[7:0] + 8'h05})
		axi_read(CTMC_ADDR_TIMER_STAT, rd, rs);
		`CHK(rd, {16'h0000, snap[15:8] + 8'h05, snap[7:0] + 8'h05})
		`CHK(rs, CTMC_RESP_OKAY)
		capture_run(CTMC_EDGE_FALL, 5, 5);
		capture_run(CTMC_EDGE_RISE, 5, 5);
		capture_run(CTMC_EDGE_RISE16, 20, 1);
		capture_run(CTMC_EDGE_RISE4, 2, 0);
		capture_run(CTMC_EDGE_RISE4, 3, 0);
		capture_run(CTMC_EDGE_RISE4, 4, 1);
		print_verdict();
	end
endmodule : capture_timer_mode_control_test

// >>> ctmc_capture_timer_mode_control.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps

module ctmc_capture_timer_mode_control
	import ctmc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ext_timer_clk,
	input  wire logic [1:0]  capture_in,
	output logic [1:0]       capture_event,
	output logic [7:0]       timer1_count,
	output logic [7:0]       timer2_count,
	output logic [7:0]       mode_ctrl
);

	logic [7:0]  mode_ctrl_r;
	logic        awready_r;
	logic        wready_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic        aw_got_r;
	logic        w_got_r;
	logic [11:0] awaddr_r;
	logic [7:0]  wbyte_r;
	logic        wstrb0_r;
	logic [1:0]  div_r;
	logic        ext_prev_r;
	logic [7:0]  timer1_r;
	logic [7:0]  timer2_r;
	wire  [1:0]  cap_event_w;

	// Write channel handshakes
	wire         aw_ok      = s_axi_awvalid & awready_r;
	wire         w_ok       = s_axi_wvalid & wready_r;
	wire         aw_have    = aw_got_r | aw_ok;
	wire         w_have     = w_got_r | w_ok;
	wire         do_write   = aw_have & w_have & ~bvalid_r;
	wire [11:0]  wr_addr    = aw_got_r ? awaddr_r : s_axi_awaddr;
	wire [7:0]   wr_byte    = w_got_r ? wbyte_r : s_axi_wdata[7:0];
	wire         wr_strb0   = w_got_r ? wstrb0_r : s_axi_wstrb[0];
	wire         wr_hit_ctl = wr_addr == CTMC_ADDR_MODE_CTRL;
	wire         wr_hit_sts = wr_addr == CTMC_ADDR_TIMER_STAT;
	wire         ctl_write  = do_write & wr_hit_ctl & wr_strb0;
	wire         b_done     = bvalid_r & s_axi_bready;
	wire         aw_got_nxt = do_write ? 1'b0 : aw_have;
	wire         w_got_nxt  = do_write ? 1'b0 : w_have;
	wire         bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready);

	// Read channel
	wire         ar_ok      = s_axi_arvalid & arready_r;
	wire         r_done     = rvalid_r & s_axi_rready;
	wire         rd_hit_ctl = s_axi_araddr == CTMC_ADDR_MODE_CTRL;
	wire         rd_hit_sts = s_axi_araddr == CTMC_ADDR_TIMER_STAT;
	wire [31:0]  rd_data    = rd_hit_ctl ? {24'h000000, mode_ctrl_r} :
	                          rd_hit_sts ? {16'h0000, timer2_r, timer1_r} : 32'h00000000;
	wire [1:0]   rd_resp    = (rd_hit_ctl | rd_hit_sts) ? CTMC_RESP_OKAY : CTMC_RESP_SLVERR;

	// Control fields
	wire         cascade    = mode_ctrl_r[CTMC_CASCADE_BIT];
	wire         t1_ext     = mode_ctrl_r[CTMC_TIMER1_SRC_BIT];
	wire         t2_ext     = mode_ctrl_r[CTMC_TIMER2_SRC_BIT];

	// Timer clocking
	wire         instr_tick = div_r == CTMC_INSTR_DIV_LAST;
	wire         ext_fall   = ext_prev_r & ~ext_timer_clk;
	wire         t1_inc     = t1_ext ? ext_fall : instr_tick;
	wire         t1_wrap    = t1_inc & (timer1_r == CTMC_TIMER_MAX);
	wire         t2_own_inc = t2_ext ? ext_fall : instr_tick;
	wire         t2_inc     = cascade ? t1_wrap : t2_own_inc;

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign capture_event = cap_event_w;
	assign timer1_count  = timer1_r;
	assign timer2_count  = timer2_r;
	assign mode_ctrl     = mode_ctrl_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= CTMC_RESP_OKAY;
		end else begin
			aw_got_r  <= aw_got_nxt;
			w_got_r   <= w_got_nxt;
			awready_r <= ~aw_got_nxt & ~bvalid_nxt;
			wready_r  <= ~w_got_nxt & ~bvalid_nxt;
			bvalid_r  <= bvalid_nxt;
			if (do_write) begin
				bresp_r <= (wr_hit_ctl | wr_hit_sts) ? CTMC_RESP_OKAY : CTMC_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= 12'h000;
			wbyte_r  <= 8'h00;
			wstrb0_r <= 1'b0;
		end else begin
			if (aw_ok) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_ok) begin
				wbyte_r  <= s_axi_wdata[7:0];
				wstrb0_r <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ctrl_r <= CTMC_MODE_CTRL_RESET;
		end else if (ctl_write) begin
			mode_ctrl_r <= wr_byte;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= CTMC_RESP_OKAY;
		end else begin
			if (ar_ok) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rd_data;
				rresp_r   <= rd_resp;
			end else if (r_done) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end else if (!rvalid_r) begin
				arready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r      <= 2'h0;
			ext_prev_r <= 1'b0;
			timer1_r   <= 8'h00;
			timer2_r   <= 8'h00;
		end else begin
			div_r      <= div_r + 2'h1;
			ext_prev_r <= ext_timer_clk;
			if (t1_inc) begin
				timer1_r <= timer1_r + 8'h01;
			end
			if (t2_inc) begin
				timer2_r <= timer2_r + 8'h01;
			end
		end
	end

	// One edge qualifier and prescaler per capture input
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_capture
			localparam int LSB = (ch == 0) ? CTMC_FIRST_EDGE_LSB : CTMC_SECOND_EDGE_LSB;
			logic [3:0] presc_r;
			logic       prev_r;
			logic       event_r;
			wire  [1:0] edge_mode = mode_ctrl_r[LSB +: 2];
			wire        rise      = capture_in[ch] & ~prev_r;
			wire        fall      = ~capture_in[ch] & prev_r;
			wire [3:0]  last      = (edge_mode == CTMC_EDGE_RISE4) ? CTMC_PRESC_LAST4 : CTMC_PRESC_LAST16;
			wire        presc_hit = rise & (presc_r == last);
			wire        fire      = (edge_mode == CTMC_EDGE_FALL) ? fall :
			                        (edge_mode == CTMC_EDGE_RISE) ? rise : presc_hit;

			// Each channel owns its flops; the shared vector is only a net
			assign cap_event_w[ch] = event_r;

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					presc_r <= 4'h0;
					prev_r  <= 1'b0;
					event_r <= 1'b0;
				end else begin
					prev_r  <= capture_in[ch];
					event_r <= fire;
					if (ctl_write || presc_hit) begin
						presc_r <= 4'h0;
					end else if (rise) begin
						presc_r <= presc_r + 4'h1;
					end
				end
			end
		end
	endgenerate

endmodule : ctmc_capture_timer_mode_control

// >>> ctmc_checker.sv
`timescale 1ns/1ps
module ctmc_checker
	import ctmc_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic [1:0]  capture_in,
	input wire logic [1:0]  capture_event,
	input wire logic [7:0]  timer1_count,
	input wire logic [7:0]  timer2_count,
	input wire logic [7:0]  mode_ctrl
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_clear: assert property ($rose(aresetn) |-> mode_ctrl == 8'h00)
		else $error("control register not clear after reset");
	a_read_back: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) == CTMC_ADDR_MODE_CTRL |->
		s_axi_rdata == {24'h000000, mode_ctrl}) else $error("read data differs from control register");
	a_rise_first: assert property (mode_ctrl[5:4] == CTMC_EDGE_RISE && $rose(capture_in[0]) |->
		##[1:2] capture_event[0]) else $error("first rise not captured");
	a_rise_second: assert property (mode_ctrl[7:6] == CTMC_EDGE_RISE && $rose(capture_in[1]) |->
		##[1:2] capture_event[1]) else $error("second rise not captured");
	a_fall_second: assert property (mode_ctrl[7:6] == CTMC_EDGE_FALL && $fell(capture_in[1]) |->
		##[1:2] capture_event[1]) else $error("second fall not captured");
	a_cascade_carry: assert property (mode_ctrl[3] && $stable(mode_ctrl) && $past(timer1_count) == 8'hFF &&
		timer1_count == 8'h00 |-> timer2_count == $past(timer2_count) + 8'h01) else $error("no carry");
	a_timers_apart: assert property (mode_ctrl[3:0] == 4'h0 && $stable(mode_ctrl) && $changed(timer1_count)
		|-> $changed(timer2_count)) else $error("second timer not counting alone");
	a_tick_spacing: assert property (!mode_ctrl[0] && $changed(timer1_count) |=> (##[0:3] mode_ctrl[0]) or
		($stable(timer1_count) [*3] ##1 $changed(timer1_count))) else $error("tick spacing wrong");
	c_event: cover property (capture_event[0]);
	c_wrap: cover property (mode_ctrl[3] && timer1_count == 8'hFF);
	c_read: cover property (s_axi_rvalid);
endmodule : ctmc_checker

bind ctmc_capture_timer_mode_control ctmc_checker chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_araddr(s_axi_araddr), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.capture_in(capture_in), .capture_event(capture_event), .timer1_count(timer1_count),
	.timer2_count(timer2_count), .mode_ctrl(mode_ctrl));

// >>> ctmc_pkg.sv
package ctmc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  CTMC_IDX_MODE_CTRL    = 8'h16;
	localparam logic [7:0]  CTMC_IDX_TIMER_STATUS = 8'h18;
	localparam logic [11:0] CTMC_ADDR_MODE_CTRL   = {2'h0, CTMC_IDX_MODE_CTRL, 2'h0};
	localparam logic [11:0] CTMC_ADDR_TIMER_STAT  = {2'h0, CTMC_IDX_TIMER_STATUS, 2'h0};

	localparam logic [7:0]  CTMC_MODE_CTRL_RESET  = 8'h00;

	// Field positions in timer_capture_mode_control
	localparam int CTMC_SECOND_EDGE_LSB  = 6;
	localparam int CTMC_FIRST_EDGE_LSB   = 4;
	localparam int CTMC_CASCADE_BIT      = 3;
	localparam int CTMC_TIMER2_SRC_BIT   = 1;
	localparam int CTMC_TIMER1_SRC_BIT   = 0;

	// Capture edge modes
	localparam logic [1:0]  CTMC_EDGE_FALL        = 2'h0;
	localparam logic [1:0]  CTMC_EDGE_RISE        = 2'h1;
	localparam logic [1:0]  CTMC_EDGE_RISE4       = 2'h2;
	localparam logic [1:0]  CTMC_EDGE_RISE16      = 2'h3;
	localparam logic [3:0]  CTMC_PRESC_LAST4      = 4'h3;
	localparam logic [3:0]  CTMC_PRESC_LAST16     = 4'hF;

	// Instruction clock is the core clock divided by four
	localparam logic [1:0]  CTMC_INSTR_DIV_LAST   = 2'h3;
	localparam logic [7:0]  CTMC_TIMER_MAX        = 8'hFF;

	localparam logic [1:0]  CTMC_RESP_OKAY        = 2'h0;
	localparam logic [1:0]  CTMC_RESP_SLVERR      = 2'h2;

endpackage : ctmc_pkg
